/* rirq_pkg.sv */
// Constants, types and decode helpers shared by the interrupt source select block
package rirq_pkg;

    // ========================================================================
    // Register offsets
    localparam logic [7:0] ADDR_ROUTE = 8'h0d;  // Line routing and FIFO flags
    localparam logic [7:0] ADDR_FILL  = 8'h0e;  // FIFO fill method and control
    localparam logic [7:0] ADDR_STAT  = 8'h20;  // Sticky event status
    localparam logic [7:0] ADDR_MASK  = 8'h21;  // Event mask

    // ========================================================================
    // Field positions in the routing register
    localparam int IRQ0_SEL_LSB = 6;
    localparam int IRQ1_SEL_LSB = 4;
    localparam int TX1_SEL_BIT  = 3;
    localparam int FULL_BIT     = 2;
    localparam int NEMPTY_BIT   = 1;
    localparam int OVR_BIT      = 0;

    // Field positions in the fill register
    localparam int FILL_METHOD_BIT = 7;
    localparam int FILL_CTRL_BIT   = 6;

    // ========================================================================
    // Status and mask bit positions
    localparam int ST_OVR    = 0;
    localparam int ST_FULL   = 1;
    localparam int ST_NEMPTY = 2;
    localparam int ST_LEVEL  = 3;
    localparam int ST_W      = 4;

    // ========================================================================
    // Reset values
    localparam logic [4:0]      ROUTE_SEL_RST = 5'h00;
    localparam logic            OVR_RST       = 1'b0;
    localparam logic            FILL_RST      = 1'b0;
    localparam logic            METHOD_RST    = 1'b0;
    localparam logic [ST_W-1:0] STAT_RST      = 4'h0;
    localparam logic [ST_W-1:0] MASK_RST      = 4'h0;

    // ========================================================================
    // Chip state codes
    localparam logic [2:0] CHIP_SLEEP = 3'h0;
    localparam logic [2:0] CHIP_STBY  = 3'h1;
    localparam logic [2:0] CHIP_FS    = 3'h2;
    localparam logic [2:0] CHIP_RX    = 3'h3;
    localparam logic [2:0] CHIP_TX    = 3'h4;

    // ========================================================================
    // FIFO sizing: capacity is (select + 1) steps of 16 bytes
    localparam int         CNT_W     = 7;
    localparam logic [6:0] FIFO_STEP = 7'h10;

    // Data handling modes
    typedef enum logic [1:0] {DM_CONT, DM_BUF, DM_PKT} rirq_dmode_e;

    // Packet mode whenever the mode MSB is set
    function automatic rirq_dmode_e dmode_of(input logic [1:0] dm);
        if (dm[1])
            return DM_PKT;
        else if (dm[0])
            return DM_BUF;
        else
            return DM_CONT;
    endfunction

endpackage

/* rirq_flag_if.sv */
// FIFO occupancy flags passed from the level tracker to the routing logic
`timescale 1ns/100ps
interface rirq_flag_if;
    logic full;
    logic not_empty;
    logic level_hit;

    modport prod (output full, output not_empty, output level_hit);
    modport cons (input full, input not_empty, input level_hit);
endinterface

/* rirq_fifo_level.sv */
// FIFO occupancy counter with full, not-empty and level threshold flags
`timescale 1ns/100ps
module rirq_fifo_level (
    // Clock and reset
    input  wire logic       mclk,
    input  wire logic       rst_n,
    // Occupancy events
    input  wire logic       push,
    input  wire logic       pop,
    input  wire logic       flush,
    // Configuration
    input  wire logic [1:0] size_sel,
    input  wire logic [5:0] thresh,
    // Flags
    rirq_flag_if.prod       flags
);

    logic [rirq_pkg::CNT_W-1:0] count_q;
    logic [rirq_pkg::CNT_W-1:0] count_d;
    logic [rirq_pkg::CNT_W-1:0] cap;
    logic                       do_push;
    logic                       do_pop;

    // ========================================================================
    // Flags; greater-or-equal keeps full honest if the size shrinks
    always_comb
    begin
        cap             = 7'(({5'h00, size_sel} + 7'h01) * rirq_pkg::FIFO_STEP);
        flags.full      = (count_q >= cap);
        flags.not_empty = (count_q != 7'h00);
        flags.level_hit = (count_q >= {1'b0, thresh});
    end

    // ========================================================================
    // Next count; a push into a full FIFO is dropped
    always_comb
    begin
        do_push = push && !flags.full;
        do_pop  = pop && flags.not_empty;
        count_d = count_q;
        if (flush)
            count_d = 7'h00;
        else if (do_push && !do_pop)
            count_d = count_q + 7'h01;
        else if (do_pop && !do_push)
            count_d = count_q - 7'h01;
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            count_q <= 7'h00;
        else
            count_q <= count_d;
    end

endmodule // rirq_fifo_level

/* rirq_route.sv */
// Source multiplexer for the two interrupt lines
`timescale 1ns/100ps
module rirq_route (
    // Mode
    input  wire logic [2:0] chip_mode,
    input  wire logic [1:0] data_mode,
    input  wire logic       addr_filter_en,
    // Select fields
    input  wire logic [1:0] sel0,
    input  wire logic [1:0] sel1,
    input  wire logic       tx_sel,
    // Event sources
    input  wire logic       sync_event,
    input  wire logic       rssi_event,
    input  wire logic       byte_received_event,
    input  wire logic       packet_complete_event,
    input  wire logic       address_hit_event,
    input  wire logic       checksum_pass_event,
    input  wire logic       recovered_bit_clock,
    input  wire logic       tx_data_clock,
    input  wire logic       tx_complete_event,
    rirq_flag_if.cons       flags,
    // Lines
    output logic            line0,
    output logic            line1
);

    rirq_pkg::rirq_dmode_e dm;

    // ========================================================================
    // Pure combinational selection, follows selects and modes at once
    always_comb
    begin
        dm    = rirq_pkg::dmode_of(data_mode);
        line0 = 1'b0;
        line1 = 1'b0;
        case (chip_mode)
            rirq_pkg::CHIP_RX, rirq_pkg::CHIP_STBY:
            begin
                // FIFO sources stay live in standby too
                case (dm)
                    rirq_pkg::DM_CONT:
                    begin
                        line0 = (sel0 == 2'h1) ? rssi_event : sync_event;
                        line1 = recovered_bit_clock;
                    end
                    rirq_pkg::DM_BUF:
                    begin
                        case (sel0)
                            2'h0:    line0 = 1'b0;
                            2'h1:    line0 = byte_received_event;
                            2'h2:    line0 = flags.not_empty;
                            default: line0 = sync_event;
                        endcase
                    end
                    default:
                    begin
                        case (sel0)
                            2'h0:    line0 = packet_complete_event;
                            2'h1:    line0 = byte_received_event;
                            2'h2:    line0 = flags.not_empty;
                            default: line0 = addr_filter_en ? address_hit_event : sync_event;
                        endcase
                    end
                endcase
                if (dm != rirq_pkg::DM_CONT)
                begin
                    case (sel1)
                        2'h0:    line1 = (dm == rirq_pkg::DM_PKT) ? checksum_pass_event : 1'b0;
                        2'h1:    line1 = flags.full;
                        2'h2:    line1 = rssi_event;
                        default: line1 = flags.level_hit;
                    endcase
                end
            end
            rirq_pkg::CHIP_TX:
            begin
                if (dm == rirq_pkg::DM_CONT)
                    line1 = tx_data_clock;
                else
                    line1 = tx_sel ? tx_complete_event : flags.full;
            end
            default:
            begin
                line0 = 1'b0;
                line1 = 1'b0;
            end
        endcase
    end

endmodule // rirq_route

/* rirq_top.sv */
// Interrupt line source select, FIFO flags, overrun and fill control
//
// What this block does
// - In receive or standby, line 0 takes sync or RSSI in continuous mode and nothing, byte, not-empty or sync in buffered mode.
// - In packet mode line 0 takes packet complete, byte, not-empty, or address hit (filtering on) else sync.
// - In receive or standby line 1 carries the bit clock in continuous mode, else none/checksum, full, RSSI, level.
// - The FIFO sources on the lines stay active in standby as well as receive.
// - In transmit line 1 carries the data clock in continuous mode, else FIFO full or transmit complete by one bit.
// - A read-only full flag is high while the FIFO holds its configured capacity or more.
// - A read-only active-low empty flag is low while the FIFO is empty and high otherwise.
// - Data arriving while the FIFO is full sets a sticky overrun flag that holds until software clears it.
// - Writing one to the overrun flag clears it and flushes the FIFO; writing zero does nothing.
// - The fill method bit only has effect in buffered mode.
// - Fill method zero starts filling on sync detection; method one starts and stops by the software fill bit.
`timescale 1ns/100ps
module rirq_top (
    // Clock and reset
    input  wire logic       mclk,
    input  wire logic       rst_n,
    // Register port
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    // Chip state and data mode
    input  wire logic [2:0] chip_mode,
    input  wire logic [1:0] data_mode,
    input  wire logic       addr_filter_en,
    // Event sources
    input  wire logic       sync_event,
    input  wire logic       rssi_event,
    input  wire logic       byte_received_event,
    input  wire logic       packet_complete_event,
    input  wire logic       address_hit_event,
    input  wire logic       checksum_pass_event,
    input  wire logic       recovered_bit_clock,
    input  wire logic       tx_data_clock,
    input  wire logic       tx_complete_event,
    // FIFO activity
    input  wire logic       fifo_push,
    input  wire logic       fifo_pop,
    input  wire logic [1:0] fifo_size_sel,
    input  wire logic [5:0] fifo_thresh,
    // Outputs
    output logic            irq_line0,
    output logic            irq_line1,
    output logic            fifo_flush,
    output logic            fill_active,
    output logic            irq
);

    // ========================================================================
    // Declarations
    rirq_flag_if flags ();

    logic [4:0]              sel_q;
    logic [4:0]              sel_d;
    logic                    ovr_q;
    logic                    ovr_d;
    logic                    method_q;
    logic                    method_d;
    logic                    fill_q;
    logic                    fill_d;
    logic [rirq_pkg::ST_W-1:0] stat_q;
    logic [rirq_pkg::ST_W-1:0] stat_d;
    logic [rirq_pkg::ST_W-1:0] mask_q;
    logic [rirq_pkg::ST_W-1:0] mask_d;
    logic [2:0]              prev_q;
    logic [7:0]              rdata_d;
    logic                    line0_d;
    logic                    line1_d;
    logic                    line0_q;
    logic                    line1_q;
    logic                    flush_d;
    logic                    flush_q;
    logic                    fill_act_d;
    logic                    fill_act_q;
    logic                    irq_d;
    logic                    irq_q;
    logic                    wr_route;
    logic                    wr_fill;
    logic                    overrun_ev;
    logic                    buffered;
    logic [rirq_pkg::ST_W-1:0] events;

    // ========================================================================
    // Submodules
    rirq_fifo_level u_level (
        .mclk     (mclk),
        .rst_n    (rst_n),
        .push     (fifo_push),
        .pop      (fifo_pop),
        .flush    (flush_d),
        .size_sel (fifo_size_sel),
        .thresh   (fifo_thresh),
        .flags    (flags.prod)
    );

    rirq_route u_route (
        .chip_mode             (chip_mode),
        .data_mode             (data_mode),
        .addr_filter_en        (addr_filter_en),
        .sel0                  (sel_q[4:3]),
        .sel1                  (sel_q[2:1]),
        .tx_sel                (sel_q[0]),
        .sync_event            (sync_event),
        .rssi_event            (rssi_event),
        .byte_received_event   (byte_received_event),
        .packet_complete_event (packet_complete_event),
        .address_hit_event     (address_hit_event),
        .checksum_pass_event   (checksum_pass_event),
        .recovered_bit_clock   (recovered_bit_clock),
        .tx_data_clock         (tx_data_clock),
        .tx_complete_event     (tx_complete_event),
        .flags                 (flags.cons),
        .line0                 (line0_d),
        .line1                 (line1_d)
    );

    // ========================================================================
    // Register writes, overrun and fill control
    always_comb
    begin
        wr_route   = reg_wr && (reg_addr == rirq_pkg::ADDR_ROUTE);
        wr_fill    = reg_wr && (reg_addr == rirq_pkg::ADDR_FILL);
        buffered   = (rirq_pkg::dmode_of(data_mode) == rirq_pkg::DM_BUF);
        overrun_ev = fifo_push && flags.full;
        sel_d      = wr_route ? reg_wdata[7:3] : sel_q;
        // Clear by writing one, flush rides on the same write
        flush_d    = wr_route && reg_wdata[rirq_pkg::OVR_BIT];
        // A new overrun in the clearing cycle wins
        ovr_d      = overrun_ev || (ovr_q && !flush_d);
        method_d   = wr_fill ? reg_wdata[rirq_pkg::FILL_METHOD_BIT] : method_q;
        // Method in force before the write decides how it is read
        if (!method_q)
            fill_d = (buffered && sync_event)
                   || (fill_q && !(wr_fill && reg_wdata[rirq_pkg::FILL_CTRL_BIT]));
        else
            fill_d = wr_fill ? reg_wdata[rirq_pkg::FILL_CTRL_BIT] : fill_q;
        // Outside buffered mode the fill gate stays open
        fill_act_d = !buffered || fill_d;
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            sel_q      <= rirq_pkg::ROUTE_SEL_RST;
            ovr_q      <= rirq_pkg::OVR_RST;
            method_q   <= rirq_pkg::METHOD_RST;
            fill_q     <= rirq_pkg::FILL_RST;
            flush_q    <= 1'b0;
            fill_act_q <= 1'b1;
        end
        else
        begin
            sel_q      <= sel_d;
            ovr_q      <= ovr_d;
            method_q   <= method_d;
            fill_q     <= fill_d;
            flush_q    <= flush_d;
            fill_act_q <= fill_act_d;
        end
    end

    // ========================================================================
    // Sticky status, mask and interrupt output
    always_comb
    begin
        events                      = '0;
        events[rirq_pkg::ST_OVR]    = overrun_ev;
        events[rirq_pkg::ST_FULL]   = flags.full && !prev_q[0];
        events[rirq_pkg::ST_NEMPTY] = flags.not_empty && !prev_q[1];
        events[rirq_pkg::ST_LEVEL]  = flags.level_hit && !prev_q[2];
        mask_d = (reg_wr && reg_addr == rirq_pkg::ADDR_MASK) ? reg_wdata[3:0] : mask_q;
        // Set wins over a write-one clear in the same cycle
        stat_d = events | (stat_q & ~((reg_wr && reg_addr == rirq_pkg::ADDR_STAT)
                                      ? reg_wdata[3:0] : 4'h0));
        irq_d  = |(stat_d & mask_d);
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            stat_q <= rirq_pkg::STAT_RST;
            mask_q <= rirq_pkg::MASK_RST;
            prev_q <= 3'h0;
            irq_q  <= 1'b0;
        end
        else
        begin
            stat_q <= stat_d;
            mask_q <= mask_d;
            prev_q <= {flags.level_hit, flags.not_empty, flags.full};
            irq_q  <= irq_d;
        end
    end

    // ========================================================================
    // Read mux; unmapped offsets read zero
    always_comb
    begin
        rdata_d = 8'h00;
        if (reg_rd)
        begin
            case (reg_addr)
                rirq_pkg::ADDR_ROUTE: rdata_d = {sel_q, flags.full, flags.not_empty, ovr_q};
                rirq_pkg::ADDR_FILL:  rdata_d = {method_q, fill_q, 6'h00};
                rirq_pkg::ADDR_STAT:  rdata_d = {4'h0, stat_q};
                rirq_pkg::ADDR_MASK:  rdata_d = {4'h0, mask_q};
                default:              rdata_d = 8'h00;
            endcase
        end
    end

    // Lines pass one flop so every output is registered
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            reg_rdata <= 8'h00;
            line0_q   <= 1'b0;
            line1_q   <= 1'b0;
        end
        else
        begin
            reg_rdata <= rdata_d;
            line0_q   <= line0_d;
            line1_q   <= line1_d;
        end
    end

    assign irq_line0   = line0_q;
    assign irq_line1   = line1_q;
    assign fifo_flush  = flush_q;
    assign fill_active = fill_act_q;
    assign irq         = irq_q;

    // ========================================================================
    // Assertions
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);

    logic rxsb;
    assign rxsb = (chip_mode == rirq_pkg::CHIP_RX) || (chip_mode == rirq_pkg::CHIP_STBY);

    AST_IRQ0_BUF_BYTE: assert property (rxsb && data_mode == 2'h1 && sel_q[4:3] == 2'h1 && !wr_route
        |=> irq_line0 == $past(byte_received_event))
        else $error("line 0 not byte event in buffered mode");
    AST_IRQ0_PKT_ADDR: assert property (rxsb && data_mode[1] && sel_q[4:3] == 2'h3 && !wr_route
        |=> irq_line0 == ($past(addr_filter_en) ? $past(address_hit_event) : $past(sync_event)))
        else $error("line 0 packet select 11 wrong");
    AST_IRQ1_CONT_CLK: assert property (rxsb && data_mode == 2'h0
        |=> irq_line1 == $past(recovered_bit_clock))
        else $error("line 1 not bit clock in continuous mode");
    AST_STBY_FULL: assert property (chip_mode == rirq_pkg::CHIP_STBY && data_mode == 2'h1
        && sel_q[2:1] == 2'h1 && !wr_route |=> irq_line1 == $past(flags.full))
        else $error("full not routed in standby");
    AST_TX_LINE1: assert property (chip_mode == rirq_pkg::CHIP_TX && data_mode != 2'h0 && !wr_route
        |=> irq_line1 == ($past(sel_q[0]) ? $past(tx_complete_event) : $past(flags.full)))
        else $error("transmit line 1 wrong source");
    AST_FULL_READ: assert property (reg_rd && reg_addr == rirq_pkg::ADDR_ROUTE
        |=> reg_rdata[rirq_pkg::FULL_BIT] == $past(flags.full))
        else $error("full flag read wrong");
    AST_NEMPTY_READ: assert property (reg_rd && reg_addr == rirq_pkg::ADDR_ROUTE
        |=> reg_rdata[rirq_pkg::NEMPTY_BIT] == $past(flags.not_empty))
        else $error("not-empty flag read wrong");
    AST_OVR_SET: assert property (fifo_push && flags.full |=> ovr_q [*2] or (ovr_q ##1 $past(flush_d)))
        else $error("overrun not set or not held");
    AST_OVR_CLR: assert property (flush_d && !overrun_ev |=> !ovr_q && fifo_flush && !flags.not_empty)
        else $error("overrun clear did not clear and flush");
    AST_OVR_W0: assert property (wr_route && !reg_wdata[0] && ovr_q |=> ovr_q && !fifo_flush)
        else $error("writing zero changed overrun");
    AST_FILL_OUTSIDE: assert property (data_mode != 2'h1 |=> fill_active)
        else $error("fill gate closed outside buffered mode");
    AST_FILL_AUTO: assert property (data_mode == 2'h1 && !method_q && sync_event |=> fill_active)
        else $error("sync did not start filling");

    // Select codes and flag paths the checks above leave open
    AST_IRQ0_CONT_RSSI: assert property (rxsb && data_mode == 2'h0 && sel_q[4:3] == 2'h1 && !wr_route
        |=> irq_line0 == $past(rssi_event))
        else $error("line 0 not RSSI in continuous mode");
    AST_IRQ1_PKT_CRC: assert property (rxsb && data_mode[1] && sel_q[2:1] == 2'h0 && !wr_route
        |=> irq_line1 == $past(checksum_pass_event))
        else $error("line 1 not checksum in packet mode");
    AST_IRQ1_BUF_NONE: assert property (rxsb && data_mode == 2'h1 && sel_q[2:1] == 2'h0 && !wr_route
        |=> !irq_line1)
        else $error("line 1 not quiet for buffered select 00");
    AST_OVR_HOLD: assert property (ovr_q && !flush_d |=> ovr_q)
        else $error("overrun dropped without a clear");
    AST_FILL_MANUAL: assert property (data_mode == 2'h1 && method_q && wr_fill
        |=> fill_active == $past(reg_wdata[rirq_pkg::FILL_CTRL_BIT]))
        else $error("manual fill bit not followed");

    COV_OVERRUN: cover property (fifo_push && flags.full ##1 flush_d);
    COV_PKT_DONE: cover property (rxsb && data_mode[1] && packet_complete_event ##1 irq_line0);
    COV_TX_DONE: cover property (chip_mode == rirq_pkg::CHIP_TX && sel_q[0] && tx_complete_event);
    COV_IRQ: cover property (!irq ##1 irq);
    COV_STBY_FULL: cover property (chip_mode == rirq_pkg::CHIP_STBY && irq_line1 && flags.full);

endmodule // rirq_top

/* rirq_host.sv */
// Host register port model with one access task
`timescale 1ns/100ps
module rirq_host (
    // Bus
    input  wire logic       mclk,
    input  wire logic [7:0] reg_rdata,
    output logic      [7:0] reg_addr,
    output logic      [7:0] reg_wdata,
    output logic            reg_wr,
    output logic            reg_rd
);
    initial {reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
    // One-cycle strobe; idle bus shows inverted values so stale data never passes
    task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
        @(posedge mclk);
        {reg_wr, reg_rd, reg_addr, reg_wdata} <= {w, !w, a, d};
        @(posedge mclk);
        {reg_wr, reg_rd, reg_addr, reg_wdata} <= {2'b00, ~a, ~d};
        #1 q = reg_rdata;
    endtask
endmodule // rirq_host

/* tb.sv */
// Self-checking bench for the interrupt source select block
`timescale 1ns/100ps
module tb;
    logic       mclk = 0, rst_n = 0, afe = 0, push = 0, pop = 0;
    logic [2:0] cm = 3'h3;
    logic [1:0] dm = 2'h2, fsz = 2'h0;
    logic [8:0] src = '0;
    logic [7:0] rdata, addr, wdata, q;
    logic       wr, rd, l0, l1, flush, fill, irq;
    int         mismatches = 0, n_compared = 0, cyc = 0;
    always #10 mclk = ~mclk;
    rirq_host host (.mclk(mclk), .reg_rdata(rdata), .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd));
    rirq_top uut (.mclk(mclk), .rst_n(rst_n), .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd),
        .reg_rdata(rdata), .chip_mode(cm), .data_mode(dm), .addr_filter_en(afe), .sync_event(src[0]),
        .rssi_event(src[1]), .byte_received_event(src[2]), .packet_complete_event(src[3]),
        .address_hit_event(src[4]), .checksum_pass_event(src[5]), .recovered_bit_clock(src[6]),
        .tx_data_clock(src[7]), .tx_complete_event(src[8]), .fifo_push(push), .fifo_pop(pop),
        .fifo_size_sel(fsz), .fifo_thresh(6'h04), .irq_line0(l0), .irq_line1(l1), .fifo_flush(flush),
        .fill_active(fill), .irq(irq));
    task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
        n_compared++;
        if (s !== e)
        begin
            mismatches++;
            $display("unexpected %s: expected %h seen %h", n, e, s);
        end
    endtask
    task automatic end_of_test;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // Hang guard: whole run needs well under this many cycles
    always @(posedge mclk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            mismatches++;
            end_of_test();
        end
    end
    // Source alone high, then all others high; the line trails its source by one cycle
    task automatic route(input logic [2:0] c, input logic [1:0] d, input logic a, input logic [7:0] r,
                         input int i, input logic ln);
        host.acc(1, 8'h0d, r, q);
        @(posedge mclk);
        {cm, dm, afe, src} <= {c, d, a, 9'h1 << i};
        repeat (2) @(posedge mclk);
        #1 chk("line on", ln ? l1 : l0, i < 9);
        @(posedge mclk);
        src <= ~(9'h1 << i);
        repeat (2) @(posedge mclk);
        #1 chk("line off", ln ? l1 : l0, 0);
    endtask
    // n bytes in, or n bytes out when p is set
    task automatic pushn(input int n, input logic p = 0);
        @(posedge mclk);
        {push, pop} <= {!p, p};
        repeat (n) @(posedge mclk);
        {push, pop} <= 2'b00;
        repeat (2) @(posedge mclk);
    endtask
    task automatic settle;
        repeat (2) @(posedge mclk);
        #1;
    endtask
    initial
    begin
        repeat (10) @(posedge mclk);
        rst_n <= 1;
        host.acc(0, 8'h0d, 0, q);
        chk("route reg", q, 8'h00);
        chk("fill reset", fill, 1);
        host.acc(0, 8'h33, 0, q);
        chk("unmapped", q, 8'h00);
        // Event source select codes in receive, standby and transmit; the receive and standby FIFO flag select codes are not driven here
        route(3'h3, 2'h0, 0, 8'h00, 0, 0);
        route(3'h3, 2'h0, 0, 8'h40, 1, 0);
        route(3'h3, 2'h1, 0, 8'h00, 9, 0);
        route(3'h3, 2'h1, 0, 8'h40, 2, 0);
        route(3'h3, 2'h1, 0, 8'hc0, 0, 0);
        route(3'h1, 2'h2, 0, 8'h00, 3, 0);
        route(3'h3, 2'h3, 0, 8'h40, 2, 0);
        route(3'h3, 2'h2, 1, 8'hc0, 4, 0);
        route(3'h3, 2'h2, 0, 8'hc0, 0, 0);
        route(3'h3, 2'h0, 0, 8'h00, 6, 1);
        route(3'h3, 2'h2, 0, 8'h00, 5, 1);
        route(3'h1, 2'h1, 0, 8'h20, 1, 1);
        route(3'h3, 2'h1, 0, 8'h00, 9, 1);
        route(3'h4, 2'h0, 0, 8'h00, 7, 1);
        route(3'h4, 2'h1, 0, 8'h08, 8, 1);
        route(3'h4, 2'h2, 0, 8'h00, 9, 1);
        $display("routing test done");
        // Fill a 16-byte FIFO in standby, overrun it, clear and flush
        @(posedge mclk);
        {cm, dm, src} <= {3'h1, 2'h1, 9'h0};
        host.acc(1, 8'h0d, 8'h10, q);
        pushn(15);
        host.acc(0, 8'h0d, 0, q);
        chk("one short", q, 8'h12);
        pushn(1);
        #1 chk("line1 full", l1, 1);
        host.acc(0, 8'h0d, 0, q);
        chk("full", q, 8'h16);
        pushn(1);
        host.acc(0, 8'h0d, 0, q);
        chk("overrun", q, 8'h17);
        host.acc(1, 8'h0d, 8'h10, q);
        host.acc(0, 8'h0d, 0, q);
        chk("write zero", q, 8'h17);
        host.acc(0, 8'h20, 0, q);
        chk("status", q, 8'h0f);
        chk("masked irq", irq, 0);
        host.acc(1, 8'h21, 8'h01, q);
        settle();
        chk("irq", irq, 1);
        host.acc(1, 8'h0d, 8'h11, q);
        chk("flush", flush, 1);
        host.acc(0, 8'h0d, 0, q);
        chk("cleared", q, 8'h10);
        host.acc(1, 8'h20, 8'h0f, q);
        settle();
        chk("irq clear", irq, 0);
        // 32-byte FIFO: half, full, then drained by reads
        fsz <= 2'h1;
        pushn(16);
        host.acc(0, 8'h0d, 0, q);
        chk("half of 32", q, 8'h12);
        pushn(16);
        host.acc(0, 8'h0d, 0, q);
        chk("full of 32", q, 8'h16);
        pushn(32, 1);
        host.acc(0, 8'h0d, 0, q);
        chk("drained", q, 8'h10);
        $display("fifo test done");
        // Fill gate: software stop, sync start, then manual control
        host.acc(1, 8'h0e, 8'h40, q);
        settle();
        chk("fill stop", fill, 0);
        @(posedge mclk);
        src <= 9'h1;
        @(posedge mclk);
        src <= 9'h0;
        settle();
        chk("fill sync", fill, 1);
        host.acc(1, 8'h0e, 8'h80, q);
        host.acc(1, 8'h0e, 8'h80, q);
        settle();
        chk("manual off", fill, 0);
        host.acc(1, 8'h0e, 8'hc0, q);
        settle();
        chk("manual on", fill, 1);
        host.acc(1, 8'h0e, 8'h80, q);
        @(posedge mclk);
        dm <= 2'h2;
        settle();
        chk("fill packet", fill, 1);
        $display("fill test done");
        end_of_test();
    end
endmodule // tb
